// file: bench/test_rx_polling_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_polling_timebase;
    import rx_poll_pkg::*;
    // ==========================================
    // Setup
    // ==========================================
    // Shortened counts keep the run small; expectations derive from these
    localparam int PLL = 40;
    localparam int SU = 2;
    localparam int SP [4] = '{9, 7, 5, 3};
    logic clk = 0;
    logic nrst = 0;
    logic hsel = 0;
    logic hwrite = 0;
    logic rxData = 0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] q;
    logic [31:0] w;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] seed = 32'h258a_794b;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, synthOn, sigProcOn, rxActive, basePulse, extPulse;
    wire logic [4:0] obs = {rxActive, sigProcOn, synthOn, extPulse, basePulse};
    int errors = 0, n_tests = 0, cyc = 0, tee = 0, cnt = 0, ts, tp, tq, p;
    assign hready = hreadyout;

    rx_polling_timebase #(.PLL_CYC(PLL), .SP_BASE0(SP[0]), .SP_BASE1(SP[1]), .SP_BASE2(SP[2]),
        .SP_BASE3(SP[3]), .SLEEP_UNIT(SU)) dut (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxData(rxData), .synthOn(synthOn), .sigProcOn(sigProcOn),
        .rxActive(rxActive), .basePulse(basePulse), .extPulse(extPulse));

    always #2.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctl(input int en, x, r, c);
        return 32'(en | (x << 1) | (r << 2) | (c << 4));
    endfunction

    // ==========================================
    // Receive chain stand-in
    // ==========================================
    // tee > 0: fixed edge spacing; tee < 0: random spacing inside the limits
    always @(posedge clk) begin
        if (tee != 0) begin
            if (cnt <= 0) begin
                rxData <= ~rxData;
                cnt <= (tee > 0) ? tee - 1 : int'((6 + rnd() % 5) * 16 - 1);
            end else begin
                cnt <= cnt - 1;
            end
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            $display("unexpected at %0t: run did not finish", $time);
            close_out();
        end
    end

    // ==========================================
    // Tasks
    // ==========================================
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        n_tests++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected at %0t: %s took %0d, want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        chk_val({31'h0, hresp}, 32'h0000_0000, "response");
    endtask

    // Sampled on the falling edge so every update of the rising edge has landed
    task automatic wait_for(input int b, input logic v, output int n);
        n = 0;
        @(negedge clk);
        while (obs[b] !== v) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic period(input int b, output int pr);
        int x;
        wait_for(b, 1'b1, x);
        wait_for(b, 1'b1, pr);
        pr++;
    endtask

    // Forces OFF, starts one polling cycle, times each phase
    task automatic cycle(input logic [31:0] c);
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_CTRL, c);
        wait_for(2, 1'b1, ts);
        wait_for(3, 1'b1, tp);
        tp++;
        tq = 0;
        do begin
            @(negedge clk);
            tq++;
        end while (rxActive !== 1'b1 && sigProcOn === 1'b1 && tq < 5000);
    endtask

    // ==========================================
    // Sequence
    // ==========================================
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk_val(q, 32'h0000_0000, "control reset");
        bus(1'b0, ADDR_SLEEP, 32'h0000_0000);
        chk_val(q, 32'h0000_0101, "sleep reset");
        bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
        chk_val(q, 32'h0000_0c04, "limit reset");
        bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk_val(q, 32'h0000_0000, "unmapped");
        bus(1'b1, ADDR_STATUS, 32'h0000_0007);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk_val(q & 32'h0000_0007, 32'h0000_0000, "status read only");
        // Random words through both writable setting registers; only the mapped fields keep their bits
        repeat (4) begin
            w = rnd();
            bus(1'b1, ADDR_SLEEP, w);
            bus(1'b0, ADDR_SLEEP, 32'h0000_0000);
            chk_val(q, w & 32'h0000_ff1f, "sleep random");
            w = rnd();
            bus(1'b1, ADDR_LIMIT, w);
            bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
            chk_val(q, w & 32'h0000_ffff, "limit random");
        end
        bus(1'b1, ADDR_LIMIT, 32'h0000_0c04);
        bus(1'b0, ADDR_LIMIT, 32'h0000_0000);
        chk_val(q, 32'h0000_0c04, "limit restore");
        bus(1'b1, ADDR_SLEEP, 32'h0000_0302);
        bus(1'b0, ADDR_SLEEP, 32'h0000_0000);
        chk_val(q, 32'h0000_0302, "sleep write");
        period(0, p);
        chk_rng(p, 16, 16, "base period");
        for (int x = 0; x < 2; x++) begin
            for (int r = 0; r < 4; r++) begin
                bus(1'b1, ADDR_CTRL, ctl(0, x, r, 0));
                period(1, p);
                chk_rng(p, 16 * ((8 << x) >> r), 16 * ((8 << x) >> r), "extended period");
                chk_val({31'h0, obs[0]}, 32'h0000_0001, "extended on base");
            end
        end
        // Sleep count 2, factor 3; check length 0 passes straight to receive
        for (int r = 0; r < 4; r++) begin
            cycle(ctl(1, 0, r, 0));
            chk_rng(ts, 2 * 3 * SU * 16 - 16, 2 * 3 * SU * 16 + 6, "sleep");
            chk_rng(tp, PLL, PLL, "synth start");
            chk_rng(tq, SP[r] * 16 - 16, SP[r] * 16 + 6, "sigproc start");
            chk_val({31'h0, rxActive}, 32'h0000_0001, "receive");
        end
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk_val(q & 32'h0000_0007, 32'h0000_0005, "receive state");
        bus(1'b1, ADDR_SLEEP, 32'h0000_0101);
        tee <= 128;
        for (int c = 1; c < 4; c++) begin
            cycle(ctl(1, 0, 3, c));
            chk_rng(tq, SP[3] * 16 - 16 + 6 * c * 128, SP[3] * 16 + 12 + (6 * c + 1) * 128, "check");
            chk_val({31'h0, rxActive}, 32'h0000_0001, "check pass");
        end
        tee <= -1;
        repeat (2) begin
            cycle(ctl(1, 0, 3, 3));
            // Nine bits are eighteen intervals of 96 to 160 clocks, plus the wait for the first edge
            chk_rng(tq, SP[3] * 16 - 16 + 18 * 96, SP[3] * 16 + 12 + 19 * 160, "random check");
            chk_val({31'h0, rxActive}, 32'h0000_0001, "random pass");
        end
        // No edges at all, then edges closer than the lower limit
        for (int k = 0; k < 2; k++) begin
            tee <= k * 32;
            cycle(ctl(1, 0, 3, 3));
            chk_rng(tq, SP[3] * 16 - 16, SP[3] * 16 + 6 + 14 * 16, "failed check");
            chk_val({30'h0, rxActive, synthOn}, 32'h0000_0000, "back to sleep");
            wait_for(2, 1'b1, ts);
            chk_rng(ts, SU * 16 - 16, SU * 16 + 8, "sleep again");
        end
        close_out();
    end
endmodule
`default_nettype wire

// file: logic/rx_poll_pkg.sv
package rx_poll_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CRYSTAL_PER_BASE = 16;
    localparam int SLEEP_UNIT_BASE = 1024;
    // Synthesizer start-up in half base periods (798.5 base periods)
    localparam int PLL_STARTUP_HALF_BASE = 1597;
    localparam int PLL_STARTUP_CYC = PLL_STARTUP_HALF_BASE * CRYSTAL_PER_BASE / 2;
    localparam int SIGPROC_BASE_R0 = 930;
    localparam int SIGPROC_BASE_R1 = 546;
    localparam int SIGPROC_BASE_R2 = 354;
    localparam int SIGPROC_BASE_R3 = 258;
    localparam int CNT_W = 24;
    localparam int INTV_W = 8;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLEEP = 8'h04;
    localparam logic [7:0] ADDR_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EXTLIM_BIT = 1;
    localparam int CTRL_RANGE_LSB = 2;
    localparam int CTRL_NCHK_LSB = 4;
    localparam int SLEEP_CNT_LSB = 0;
    localparam int SLEEP_XF_LSB = 8;
    localparam int LIMIT_MIN_LSB = 0;
    localparam int LIMIT_MAX_LSB = 8;

    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [4:0] SLEEP_CNT_RESET = 5'h01;
    localparam logic [7:0] SLEEP_XF_RESET = 8'h01;
    localparam logic [7:0] LIMIT_MIN_RESET = 8'h04;
    localparam logic [7:0] LIMIT_MAX_RESET = 8'h0C;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_SLEEP = 3'b001,
        ST_PLL = 3'b010,
        ST_SIGPROC = 3'b011,
        ST_BITCHK = 3'b100,
        ST_RECEIVE = 3'b101
    } phase_e;
endpackage

// file: logic/rx_polling_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module rx_polling_timebase #(
    parameter int PLL_CYC = rx_poll_pkg::PLL_STARTUP_CYC, // Synth start-up in clocks
    parameter int SP_BASE0 = rx_poll_pkg::SIGPROC_BASE_R0, // Sigproc start-up, range 0
    parameter int SP_BASE1 = rx_poll_pkg::SIGPROC_BASE_R1, // Sigproc start-up, range 1
    parameter int SP_BASE2 = rx_poll_pkg::SIGPROC_BASE_R2, // Sigproc start-up, range 2
    parameter int SP_BASE3 = rx_poll_pkg::SIGPROC_BASE_R3, // Sigproc start-up, range 3
    parameter int SLEEP_UNIT = rx_poll_pkg::SLEEP_UNIT_BASE // Base periods per sleep unit
) (
    input wire logic clk, // 200 MHz crystal clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic rxData, // Demodulated data from receive chain
    output logic synthOn, // Synthesizer powered
    output logic sigProcOn, // Signal processing powered
    output logic rxActive, // Bit-check passed, receiving
    output logic basePulse, // Base period tick
    output logic extPulse // Extended period tick
);
    import rx_poll_pkg::*;

    logic rstMeta_ff, rstN_ff;
    logic [5:0] ctrl_ff;
    logic [4:0] sleepCnt_ff;
    logic [7:0] sleepXf_ff;
    logic [7:0] limMin_ff, limMax_ff;
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [31:0] rdData_ff;
    logic [2:0] rxSync_ff;
    logic rxLevel_ff;
    phase_e state_ff, nxt_state;
    logic [CNT_W-1:0] phaseCnt_ff;
    logic [INTV_W-1:0] intv_ff;
    logic seenEdge_ff;
    logic [4:0] goodCnt_ff;
    logic enable, extendedLimitSelect, rxEdge, goodIntv;
    logic [1:0] range;
    logic [4:0] needGood;
    logic [CNT_W-1:0] sleepTarget, spTarget;
    logic [31:0] statusWord;

    function automatic logic [4:0] ext_factor(input logic xl, input logic [1:0] r);
        ext_factor = xl ? (5'h10 >> r) : (5'h08 >> r);
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [31:0] st);
        case (a)
            ADDR_CTRL: reg_read = {26'h000_0000, ctrl_ff};
            ADDR_SLEEP: reg_read = {16'h0000, sleepXf_ff, 3'h0, sleepCnt_ff};
            ADDR_LIMIT: reg_read = {16'h0000, limMax_ff, limMin_ff};
            ADDR_STATUS: reg_read = st;
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    // ==========================================================
    // Reset release
    // ==========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_ff <= 1'b0;
            rstN_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstN_ff <= rstMeta_ff;
        end
    end

    assign enable = ctrl_ff[CTRL_EN_BIT];
    assign extendedLimitSelect = ctrl_ff[CTRL_EXTLIM_BIT];
    assign range = ctrl_ff[CTRL_RANGE_LSB +: 2];
    assign needGood = 5'({ctrl_ff[CTRL_NCHK_LSB +: 2], 1'b0}) * 5'h03; // Two edges per bit

    // ==========================================================
    // Timebase
    // ==========================================================
    timebase_divider #(
        .DIV(CRYSTAL_PER_BASE)
    ) u_div (
        .clk(clk),
        .rstN(rstN_ff),
        .extFactor(ext_factor(extendedLimitSelect, range)),
        .basePulse(basePulse),
        .extPulse(extPulse)
    );

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // ==========================================================
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdData_ff;
    assign statusWord = {23'h00_0000, goodCnt_ff, 1'b0, state_ff};

    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            rdData_ff <= 32'h0000_0000;
        end else begin
            wrPend_ff <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                wrAddr_ff <= {haddr[7:2], 2'b00};
                if (!hwrite) begin
                    rdData_ff <= reg_read({haddr[7:2], 2'b00}, statusWord);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            ctrl_ff <= CTRL_RESET;
            sleepCnt_ff <= SLEEP_CNT_RESET;
            sleepXf_ff <= SLEEP_XF_RESET;
            limMin_ff <= LIMIT_MIN_RESET;
            limMax_ff <= LIMIT_MAX_RESET;
        end else if (wrPend_ff) begin
            case (wrAddr_ff)
                ADDR_CTRL: ctrl_ff <= hwdata[5:0];
                ADDR_SLEEP: begin
                    sleepCnt_ff <= hwdata[SLEEP_CNT_LSB +: 5];
                    sleepXf_ff <= hwdata[SLEEP_XF_LSB +: 8];
                end
                ADDR_LIMIT: begin
                    limMin_ff <= hwdata[LIMIT_MIN_LSB +: 8];
                    limMax_ff <= hwdata[LIMIT_MAX_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Data input synchroniser
    // ==========================================================
    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            rxSync_ff <= 3'b000;
            rxLevel_ff <= 1'b0;
        end else begin
            rxSync_ff <= {rxSync_ff[1:0], rxData};
            if (rxSync_ff[2] == rxSync_ff[1]) begin
                rxLevel_ff <= rxSync_ff[1];
            end
        end
    end
    assign rxEdge = (rxSync_ff[2] == rxSync_ff[1]) && (rxSync_ff[1] != rxLevel_ff);

    // ==========================================================
    // Phase sequencer
    // ==========================================================
    assign sleepTarget = CNT_W'(sleepCnt_ff * sleepXf_ff) * CNT_W'(SLEEP_UNIT);
    always_comb begin
        case (range)
            2'd0: spTarget = CNT_W'(SP_BASE0);
            2'd1: spTarget = CNT_W'(SP_BASE1);
            2'd2: spTarget = CNT_W'(SP_BASE2);
            default: spTarget = CNT_W'(SP_BASE3);
        endcase
    end
    assign goodIntv = (intv_ff >= limMin_ff) && (intv_ff <= limMax_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: if (enable) nxt_state = ST_SLEEP;
            ST_SLEEP: if (phaseCnt_ff >= sleepTarget) nxt_state = ST_PLL;
            ST_PLL: if (phaseCnt_ff == CNT_W'(PLL_CYC - 1)) nxt_state = ST_SIGPROC;
            ST_SIGPROC: if (phaseCnt_ff >= spTarget) nxt_state = ST_BITCHK;
            ST_BITCHK: begin
                if (goodCnt_ff >= needGood) begin
                    nxt_state = ST_RECEIVE;
                end else if (intv_ff > limMax_ff) begin
                    nxt_state = ST_SLEEP;
                end else if (rxEdge && seenEdge_ff && !goodIntv) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_RECEIVE: ;
            default: nxt_state = ST_OFF;
        endcase
        if (!enable) begin
            nxt_state = ST_OFF;
        end
    end

    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Sleep and sigproc count base periods, synth start-up counts clocks for the half period
    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            phaseCnt_ff <= '0;
        end else if (nxt_state != state_ff) begin
            phaseCnt_ff <= '0;
        end else if (state_ff == ST_PLL || basePulse) begin
            phaseCnt_ff <= phaseCnt_ff + 1'b1;
        end
    end

    // Edge interval in extended periods; timeout also covers no first edge
    always_ff @(posedge clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            intv_ff <= '0;
            seenEdge_ff <= 1'b0;
            goodCnt_ff <= 5'h00;
        end else if (state_ff != ST_BITCHK) begin
            intv_ff <= '0;
            seenEdge_ff <= 1'b0;
            goodCnt_ff <= 5'h00;
        end else if (rxEdge) begin
            intv_ff <= '0;
            seenEdge_ff <= 1'b1;
            if (seenEdge_ff && goodIntv) begin
                goodCnt_ff <= goodCnt_ff + 5'h01;
            end
        end else if (extPulse && intv_ff != '1) begin
            intv_ff <= intv_ff + 1'b1;
        end
    end

    assign synthOn = (state_ff == ST_PLL) || (state_ff == ST_SIGPROC) || (state_ff == ST_BITCHK)
        || (state_ff == ST_RECEIVE);
    assign sigProcOn = (state_ff == ST_SIGPROC) || (state_ff == ST_BITCHK) || (state_ff == ST_RECEIVE);
    assign rxActive = (state_ff == ST_RECEIVE);

    // ==========================================================
    // Checks
    // ==========================================================
    chk_base_spacing: assert property (@(posedge clk) disable iff (!rstN_ff)
        basePulse |-> ##16 basePulse) else $error("base tick not every 16 clocks");
    chk_base_quiet: assert property (@(posedge clk) disable iff (!rstN_ff)
        basePulse |=> (!basePulse)[*8] ##1 (!basePulse)[*7]) else $error("base tick too early");
    chk_ext_on_base: assert property (@(posedge clk) disable iff (!rstN_ff)
        extPulse |-> basePulse) else $error("extended tick off base tick");
    chk_sleep_length: assert property (@(posedge clk) disable iff (!rstN_ff)
        (state_ff == ST_PLL && $past(state_ff) == ST_SLEEP) |-> $past(phaseCnt_ff) >= $past(sleepTarget))
        else $error("sleep ended early");
    chk_pll_length: assert property (@(posedge clk) disable iff (!rstN_ff)
        (state_ff == ST_SIGPROC && $past(state_ff) == ST_PLL) |-> $past(phaseCnt_ff) == CNT_W'(PLL_CYC - 1))
        else $error("synth start-up wrong length");
    chk_sigproc_length: assert property (@(posedge clk) disable iff (!rstN_ff)
        (state_ff == ST_BITCHK && $past(state_ff) == ST_SIGPROC) |-> $past(phaseCnt_ff) == $past(spTarget))
        else $error("sigproc start-up wrong length");
    chk_check_pass: assert property (@(posedge clk) disable iff (!rstN_ff)
        $rose(rxActive) |-> $past(goodCnt_ff) == $past(needGood)) else $error("bit-check pass miscounted");
    chk_check_timeout: assert property (@(posedge clk) disable iff (!rstN_ff)
        (state_ff == ST_BITCHK && enable && intv_ff > limMax_ff && goodCnt_ff < needGood) |=> state_ff == ST_SLEEP)
        else $error("bit-check did not abort");
    chk_phase_order: assert property (@(posedge clk) disable iff (!rstN_ff)
        (state_ff == ST_PLL && $past(state_ff) != ST_PLL) |-> $past(state_ff) == ST_SLEEP)
        else $error("synth start-up out of order");
    chk_bus_okay: assert property (@(posedge clk) disable iff (!rstN_ff)
        hreadyout && !hresp) else $error("bus answer not OKAY");
endmodule
`default_nettype wire

// file: logic/timebase_divider.sv
`timescale 1ns/1ps
`default_nettype none
module timebase_divider #(
    parameter int DIV = 16
) (
    input wire logic clk, // Crystal clock
    input wire logic rstN, // Synchronised reset
    input wire logic [4:0] extFactor, // Extended multiplier, 1..16
    output logic basePulse, // One cycle every DIV clocks
    output logic extPulse // One cycle every extFactor base pulses
);
    logic [$clog2(DIV)-1:0] divCnt_ff;
    logic [4:0] extCnt_ff;

    // ==========================================================
    // Base period divider
    // ==========================================================
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            divCnt_ff <= '0;
        end else if (divCnt_ff == $clog2(DIV)'(DIV - 1)) begin
            divCnt_ff <= '0;
        end else begin
            divCnt_ff <= divCnt_ff + 1'b1;
        end
    end
    assign basePulse = (divCnt_ff == $clog2(DIV)'(DIV - 1));

    // ==========================================================
    // Extended period, counted in base pulses
    // ==========================================================
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            extCnt_ff <= 5'h00;
        end else if (basePulse) begin
            if (extCnt_ff + 5'h01 >= extFactor) begin
                extCnt_ff <= 5'h00;
            end else begin
                extCnt_ff <= extCnt_ff + 5'h01;
            end
        end
    end
    assign extPulse = basePulse && (extCnt_ff + 5'h01 >= extFactor);
endmodule
`default_nettype wire
